// >>> hdl/usb_endpoint_buffer_commands.sv
/*
  endpoint command interpreter: stall/unstall, validate, clear, status
  reads and setup acknowledge, plus usb-side flag updates.
  assumes usb-side event pulses are synchronous to clk and one cycle
  long, and that the processor interface delivers one command per strobe.
  the serial engine is expected to look at endpoint_halted_flag and
  nakOut itself; this block only keeps the flags and never answers a
  token on the wire. packet data phases live elsewhere.
*/
`timescale 1ns/1ps

module usb_endpoint_buffer_commands
  import ep_cmd_pkg::*;
#(
  parameter logic [ep_cmd_pkg::NUM_EP-1:0] DOUBLE_BUF = 16'h0000
) (
  // clock, reset, enable
  input  wire logic                          clk,
  input  wire logic                          rst,
  input  wire logic                          clkEn,
  // processor command port
  input  wire logic [7:0]                    cmdByte,
  input  wire logic                          cmdValid,
  output logic [7:0]                         statusData,
  output logic                               statusValid,
  // usb-side events
  input  wire logic                          setupRx,
  input  wire logic                          outPktDone,
  input  wire logic                          inPktSent,
  input  wire logic                          outTokenRx,
  input  wire logic [3:0]                    usbEp,
  output logic                               nakOut,
  // endpoint interrupt flags
  input  wire logic [ep_cmd_pkg::NUM_EP-1:0] epIrqSet,
  output logic [ep_cmd_pkg::NUM_EP-1:0]      device_interrupt_flags,
  // per-endpoint halted view for the serial engine
  output logic [ep_cmd_pkg::NUM_EP-1:0]      endpoint_halted_flag
);
  import ep_cmd_pkg::*;

  // ------------------------------------------------------------------
  // decode
  // ------------------------------------------------------------------
  logic       doStall;
  logic       doUnstall;
  logic       doValidate;
  logic       doClear;
  logic       doStatus;
  logic       doSnapshot;
  logic       doAckSetup;
  logic [3:0] epSel;

  // the strobe is gated by clkEn so a frozen block never sees a command;
  // the byte itself may wander while the strobe is low
  ep_cmd_decode u_decode (
    .cmdByte    (cmdByte),
    .cmdValid   (cmdValid && clkEn),
    .doStall    (doStall),
    .doUnstall  (doUnstall),
    .doValidate (doValidate),
    .doClear    (doClear),
    .doStatus   (doStatus),
    .doSnapshot (doSnapshot),
    .doAckSetup (doAckSetup),
    .epSel      (epSel)
  );

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  // per-endpoint flags are vectors indexed by the endpoint code; the
  // setup bookkeeping exists only once because only the control OUT
  // endpoint ever receives a SETUP packet
  logic [NUM_EP-1:0] halted_q,  halted_d;
  logic [NUM_EP-1:0] full1_q,   full1_d;    // primary buffer full
  logic [NUM_EP-1:0] full2_q,   full2_d;    // secondary buffer full
  logic [NUM_EP-1:0] toggle_q,  toggle_d;
  logic [NUM_EP-1:0] bufSel_q,  bufSel_d;
  logic [NUM_EP-1:0] irq_q,     irq_d;
  logic              setupHeld_q, setupHeld_d;
  logic              overrun_q,   overrun_d;
  logic              ctrlLock_q,  ctrlLock_d;
  logic [7:0]        statusData_q, statusData_d;
  logic              statusValid_q, statusValid_d;
  logic              nak_q,       nak_d;

  // compose the status word of one endpoint; overrun and setup-present
  // exist only for control OUT, every other endpoint reads them as 0
  function automatic logic [7:0] status_word(input logic [3:0] ep);
    logic [7:0] w;
    w = STATUS_RESET;
    w[BIT_HALTED]  = halted_q[ep];
    w[BIT_FULL2]   = full2_q[ep];
    w[BIT_FULL1]   = full1_q[ep];
    w[BIT_TOGGLE]  = toggle_q[ep];
    w[BIT_OVERRUN] = (ep == EP_CTRL_OUT) ? overrun_q : 1'b0;
    w[BIT_SETUP]   = (ep == EP_CTRL_OUT) ? setupHeld_q : 1'b0;
    w[BIT_BUFSEL]  = bufSel_q[ep];
    return w;
  endfunction

  // is the current processor buffer of an endpoint full
  function automatic logic cur_full(input logic [3:0] ep);
    return bufSel_q[ep] ? full2_q[ep] : full1_q[ep];
  endfunction

  // control endpoints are nibbles 0 and 1, the rest are data endpoints
  function automatic logic is_ctrl(input logic [3:0] ep);
    return ep == EP_CTRL_OUT || ep == EP_CTRL_IN;
  endfunction

  // ------------------------------------------------------------------
  // next-state logic
  // ------------------------------------------------------------------
  // usb events are applied first and commands after, so a processor
  // command in the same cycle has the final word on its endpoint,
  // except that hardware sets of interrupt bits beat the read clear and a SETUP blocks the overrun clear.
  // trade-off: one large process keeps every priority in one place, at
  // the cost of a long path through the per-endpoint multiplexers when
  // the endpoint count grows.
  always_comb begin
    halted_d      = halted_q;
    full1_d       = full1_q;
    full2_d       = full2_q;
    toggle_d      = toggle_q;
    bufSel_d      = bufSel_q;
    irq_d         = irq_q;
    setupHeld_d   = setupHeld_q;
    overrun_d     = overrun_q;
    ctrlLock_d    = ctrlLock_q;
    statusData_d  = statusData_q;
    statusValid_d = 1'b0;
    nak_d         = 1'b0;

    // ----------------------------------------------------------------
    // usb-side events
    // ----------------------------------------------------------------
    // setup arrival on the control endpoints
    if (setupRx) begin
      // a second SETUP before the acknowledge overwrites unanswered data
      if (setupHeld_q && ctrlLock_q && !halted_q[EP_CTRL_OUT])
        overrun_d = 1'b1;
      setupHeld_d = 1'b1;
      ctrlLock_d  = 1'b1;
      for (int e = 0; e < 2; e++) begin
        if (halted_q[e]) begin
          halted_d[e] = 1'b0;
          full1_d[e]  = 1'b0;
          full2_d[e]  = 1'b0;
          bufSel_d[e] = 1'b0;
        end
        toggle_d[e] = 1'b0;
      end
      full1_d[EP_CTRL_OUT] = 1'b1;   // setup data sits in the OUT buffer
    end

    // completed OUT packet fills the free buffer; a full one refuses
    if (outTokenRx && !halted_q[usbEp]) begin
      if (full1_q[usbEp] && (!DOUBLE_BUF[usbEp] || full2_q[usbEp]))
        nak_d = 1'b1;
    end
    if (outPktDone && !halted_q[usbEp]) begin
      if (!full1_q[usbEp])
        full1_d[usbEp] = 1'b1;
      else if (DOUBLE_BUF[usbEp])
        full2_d[usbEp] = 1'b1;
      toggle_d[usbEp] = ~toggle_q[usbEp];
    end

    // an IN packet sent empties the primary buffer if it is full, else the secondary
    if (inPktSent && !halted_q[usbEp]) begin
      if (full1_q[usbEp])
        full1_d[usbEp] = 1'b0;
      else
        full2_d[usbEp] = 1'b0;
      toggle_d[usbEp] = ~toggle_q[usbEp];
    end

    // ----------------------------------------------------------------
    // processor commands
    // ----------------------------------------------------------------
    // stalling control OUT ends the pending setup, so no later overrun
    if (doStall) begin
      halted_d[epSel] = 1'b1;
      if (epSel == EP_CTRL_OUT)
        setupHeld_d = 1'b0;
    end
    // unstalling an endpoint that is not halted leaves its buffers alone
    if (doUnstall && halted_q[epSel]) begin
      halted_d[epSel] = 1'b0;
      full1_d[epSel]  = 1'b0;
      full2_d[epSel]  = 1'b0;
      bufSel_d[epSel] = 1'b0;
      toggle_d[epSel] = 1'b0;
    end
    // validate lands in the buffer the processor currently owns
    if (doValidate && !(is_ctrl(epSel) && ctrlLock_q)) begin
      if (bufSel_q[epSel])
        full2_d[epSel] = 1'b1;
      else
        full1_d[epSel] = 1'b1;
      if (DOUBLE_BUF[epSel])
        bufSel_d[epSel] = ~bufSel_q[epSel];
    end
    // clear also drops setup-present when aimed at control OUT
    if (doClear && !(is_ctrl(epSel) && ctrlLock_q)) begin
      if (bufSel_q[epSel])
        full2_d[epSel] = 1'b0;
      else
        full1_d[epSel] = 1'b0;
      if (DOUBLE_BUF[epSel])
        bufSel_d[epSel] = ~bufSel_q[epSel];
      if (epSel == EP_CTRL_OUT)
        setupHeld_d = 1'b0;
    end
    // acknowledge reopens validate on control IN and clear on control OUT
    if (doAckSetup) begin
      ctrlLock_d  = 1'b0;
      setupHeld_d = 1'b0;
    end

    // ----------------------------------------------------------------
    // status reads
    // ----------------------------------------------------------------
    // status reads; the snapshot leaves every flag untouched
    if (doSnapshot) begin
      statusData_d  = status_word(epSel);
      statusValid_d = 1'b1;
    end
    if (doStatus) begin
      statusData_d  = status_word(epSel);
      statusValid_d = 1'b1;
      irq_d[epSel]  = 1'b0;
      // overrun only clears once the setup write has completed
      if (epSel == EP_CTRL_OUT && !setupRx)
        overrun_d = 1'b0;
    end

    // hardware set beats the read clear
    irq_d = irq_d | epIrqSet;
  end

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  // clkEn low freezes everything; the decoder is gated by it as well
  // the reset branch loads constants only, never other state, so the
  // asynchronous path stays free of any data dependence
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      halted_q      <= '0;
      full1_q       <= '0;
      full2_q       <= '0;
      toggle_q      <= '0;
      bufSel_q      <= '0;
      irq_q         <= '0;
      setupHeld_q   <= 1'b0;
      overrun_q     <= 1'b0;
      ctrlLock_q    <= 1'b0;
      statusData_q  <= STATUS_RESET;
      statusValid_q <= 1'b0;
      nak_q         <= 1'b0;
    end else if (clkEn) begin
      halted_q      <= halted_d;
      full1_q       <= full1_d;
      full2_q       <= full2_d;
      toggle_q      <= toggle_d;
      bufSel_q      <= bufSel_d;
      irq_q         <= irq_d;
      setupHeld_q   <= setupHeld_d;
      overrun_q     <= overrun_d;
      ctrlLock_q    <= ctrlLock_d;
      statusData_q  <= statusData_d;
      statusValid_q <= statusValid_d;
      nak_q         <= nak_d;
    end
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  // outputs straight from flops
  assign statusData             = statusData_q;
  assign statusValid            = statusValid_q;
  assign nakOut                 = nak_q;
  assign device_interrupt_flags = irq_q;
  assign endpoint_halted_flag   = halted_q;
endmodule

// >>> hdl/ep_cmd_pkg.sv
/*
  package: command codes, status field positions and sizes for the
  endpoint command block. assumes nothing beyond a SystemVerilog tool.
*/
package ep_cmd_pkg;
  // ----------------------------------------------------------------
  // command groups (high nibble of the command byte) and the full setup-acknowledge byte
  // ----------------------------------------------------------------
  localparam logic [3:0] GRP_STALL    = 4'h4;
  localparam logic [3:0] GRP_UNSTALL  = 4'h8;
  localparam logic [3:0] GRP_VALIDATE = 4'h6;
  localparam logic [3:0] GRP_CLEAR    = 4'h7;
  localparam logic [3:0] GRP_STATUS   = 4'h5;
  localparam logic [3:0] GRP_SNAPSHOT = 4'hd;
  localparam logic [7:0] CMD_ACK_SETUP = 8'hf4;

  // endpoint codes carried in the low nibble
  localparam logic [3:0] EP_CTRL_OUT = 4'h0;
  localparam logic [3:0] EP_CTRL_IN  = 4'h1;
  localparam int         NUM_EP      = 16;

  // ----------------------------------------------------------------
  // status word field positions
  // ----------------------------------------------------------------
  localparam int BIT_HALTED   = 7;
  localparam int BIT_FULL2    = 6;
  localparam int BIT_FULL1    = 5;
  localparam int BIT_TOGGLE   = 4;
  localparam int BIT_OVERRUN  = 3;
  localparam int BIT_SETUP    = 2;
  localparam int BIT_BUFSEL   = 1;
  localparam logic [7:0] STATUS_RESET = 8'h00;
endpackage

// >>> hdl/ep_cmd_decode.sv
/*
  command byte decoder for the endpoint command block.
  assumes a single byte is presented with a one-cycle strobe.
*/
`timescale 1ns/1ps
module ep_cmd_decode
  import ep_cmd_pkg::*;
(
  // command byte
  input  wire logic [7:0] cmdByte,
  input  wire logic       cmdValid,
  // decoded one-hot actions
  output logic            doStall,
  output logic            doUnstall,
  output logic            doValidate,
  output logic            doClear,
  output logic            doStatus,
  output logic            doSnapshot,
  output logic            doAckSetup,
  output logic [3:0]      epSel
);
  // ----------------------------------------------------------------
  // group decode
  // ----------------------------------------------------------------
  // out-of-direction codes decode to nothing
  always_comb begin
    epSel      = cmdByte[3:0];
    doStall    = cmdValid && cmdByte[7:4] == GRP_STALL;
    doUnstall  = cmdValid && cmdByte[7:4] == GRP_UNSTALL;
    doValidate = cmdValid && cmdByte[7:4] == GRP_VALIDATE
                 && cmdByte[3:0] != EP_CTRL_OUT;
    doClear    = cmdValid && cmdByte[7:4] == GRP_CLEAR
                 && cmdByte[3:0] != EP_CTRL_IN;
    doStatus   = cmdValid && cmdByte[7:4] == GRP_STATUS;
    doSnapshot = cmdValid && cmdByte[7:4] == GRP_SNAPSHOT;
    doAckSetup = cmdValid && cmdByte == CMD_ACK_SETUP;
  end
endmodule

// >>> testbench/ep_cmd_props.sv
/*
  checker for the endpoint command block, bound to its top module.
  assumes one clock domain and an asynchronous active-high reset.
*/
`timescale 1ns/1ps
module ep_cmd_props
  import ep_cmd_pkg::*;
#(
  parameter logic [15:0] DOUBLE_BUF = 16'h0000
) (
  // clock, reset, enable
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        clkEn,
  // processor command port
  input wire logic [7:0]  cmdByte,
  input wire logic        cmdValid,
  input wire logic [7:0]  statusData,
  input wire logic        statusValid,
  // usb-side events
  input wire logic        setupRx,
  input wire logic        outPktDone,
  input wire logic        inPktSent,
  input wire logic        outTokenRx,
  input wire logic [3:0]  usbEp,
  input wire logic        nakOut,
  // flags
  input wire logic [15:0] epIrqSet,
  input wire logic [15:0] device_interrupt_flags,
  input wire logic [15:0] endpoint_halted_flag
);
  // command qualifiers shared by the properties
  logic       take;
  logic       rdCmd;
  logic [3:0] grp;
  logic [3:0] sel;
  assign take  = cmdValid && clkEn;
  assign grp   = cmdByte[7:4];
  assign sel   = cmdByte[3:0];
  assign rdCmd = take && (grp == GRP_STATUS || grp == GRP_SNAPSHOT);

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  a_stall_sets_halt: assert property (take && grp == GRP_STALL |=> endpoint_halted_flag[$past(sel)])
    else $error("stall left halted flag clear");
  a_unstall_clears_halt: assert property (take && grp == GRP_UNSTALL |=> !endpoint_halted_flag[$past(sel)])
    else $error("unstall left halted flag set");
  a_setup_unhalts_ctrl: assert property (setupRx && clkEn && !cmdValid |=> endpoint_halted_flag[1:0] == 2'b00)
    else $error("setup left a control endpoint halted");
  a_read_gets_answer: assert property (rdCmd |=> statusValid)
    else $error("status read gave no answer");
  a_halt_bit_copied: assert property (rdCmd && !setupRx |=> statusData[7] == $past(endpoint_halted_flag[sel]))
    else $error("status halted bit differs from flag");
  a_reserved_bit_zero: assert property (statusValid |-> !statusData[0])
    else $error("reserved status bit set");
  a_nak_has_cause: assert property (nakOut && $past(clkEn) |-> $past(outTokenRx))
    else $error("nak without an out token");
  a_snapshot_keeps_irq: assert property (take && grp == GRP_SNAPSHOT && device_interrupt_flags[sel] |=> device_interrupt_flags[$past(sel)])
    else $error("snapshot cleared an interrupt bit");
  a_read_clears_irq: assert property (take && grp == GRP_STATUS && !epIrqSet[sel] |=> !device_interrupt_flags[$past(sel)])
    else $error("status read left interrupt bit set");
endmodule

bind usb_endpoint_buffer_commands ep_cmd_props #(.DOUBLE_BUF(DOUBLE_BUF)) u_ep_cmd_props (
  .clk(clk), .rst(rst), .clkEn(clkEn), .cmdByte(cmdByte), .cmdValid(cmdValid),
  .statusData(statusData), .statusValid(statusValid), .setupRx(setupRx),
  .outPktDone(outPktDone), .inPktSent(inPktSent), .outTokenRx(outTokenRx), .usbEp(usbEp),
  .nakOut(nakOut), .epIrqSet(epIrqSet), .device_interrupt_flags(device_interrupt_flags),
  .endpoint_halted_flag(endpoint_halted_flag));

// >>> testbench/ep_host_model.sv
/*
  host processor model: turns a bench request into a one-cycle
  command strobe. assumes requests are at least one clock apart.
*/
`timescale 1ns/1ps
module ep_host_model (
  // clock, reset
  input  wire logic       clk,
  input  wire logic       rst,
  // bench request
  input  wire logic       go,
  input  wire logic [7:0] code,
  // command port
  output logic [7:0]      cmdByte,
  output logic            cmdValid
);
  logic [7:0] byteD;
  // idle byte is the inverse of the last one so a stale code never passes
  always_comb begin
    byteD = go ? code : ~cmdByte;
  end
  // strobe and byte change together just after the edge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cmdValid <= 1'b0;
      cmdByte  <= 8'h00;
    end else begin
      cmdValid <= go;
      cmdByte  <= byteD;
    end
  end
endmodule

// >>> testbench/testbench.sv
/*
  testbench: commands go through the host model, usb events are driven
  directly; status words and flags are compared with expected values.
  assumes the package, design, checker and host model compile first.
*/
`timescale 1ns/1ps
module testbench;
  import ep_cmd_pkg::*;
  logic        clk, rst, clkEn, go, statusValid, nakOut, cmdValid;
  logic [7:0]  code, cmdByte, statusData;
  logic [3:0]  usbEv, usbEp;
  logic [15:0] irq, irqFlags, halted;
  int          n_mismatch = 0;
  int          n_compared = 0;
  int          cycles     = 0;

  // ep3 double buffered so the buffer select can move
  usb_endpoint_buffer_commands #(.DOUBLE_BUF(16'h0008)) u_usb_endpoint_buffer_commands (
    .clk(clk), .rst(rst), .clkEn(clkEn), .cmdByte(cmdByte), .cmdValid(cmdValid),
    .statusData(statusData), .statusValid(statusValid), .setupRx(usbEv[3]),
    .outPktDone(usbEv[2]), .inPktSent(usbEv[1]), .outTokenRx(usbEv[0]), .usbEp(usbEp),
    .nakOut(nakOut), .epIrqSet(irq), .device_interrupt_flags(irqFlags),
    .endpoint_halted_flag(halted));
  ep_host_model u_ep_host_model (.clk(clk), .rst(rst), .go(go), .code(code),
    .cmdByte(cmdByte), .cmdValid(cmdValid));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // the sequence needs about 290 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      summarize();
    end
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // one command; returns once its effect and any answer are visible
  task automatic cmd(input logic [7:0] c);
    @(posedge clk);
    go   <= 1'b1;
    code <= c;
    @(posedge clk);
    go <= 1'b0;
    // the design takes the strobe at this edge; one-cycle answers stand until the next
    @(posedge clk);
    #1;
  endtask
  task automatic rd(input logic [7:0] c, input logic [7:0] exp);
    cmd(c);
    check({statusValid, 7'h00, statusData}, {1'b1, 7'h00, exp});
  endtask
  // usb event pulse; bits are setup, out done, in sent, out token
  task automatic pulse(input logic [3:0] k, input logic [3:0] ep);
    @(posedge clk);
    usbEv <= k;
    usbEp <= ep;
    @(posedge clk);
    usbEv <= 4'h0;
    usbEp <= ~ep;
    // nakOut stands only for the cycle after the token, so look now
    #1;
  endtask

  initial begin
    rst   = 1'b1;
    clkEn = 1'b1;
    go    = 1'b0;
    code  = 8'h00;
    usbEv = 4'h0;
    usbEp = 4'h0;
    irq   = 16'h0000;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rd(8'hd0, 8'h00);
    check(halted, 16'h0000);
    $display("test reset done");
    for (int i = 0; i < 16; i++) begin
      cmd({4'h4, i[3:0]});
      check(halted, 16'h0001 << i);
      rd({4'hd, i[3:0]}, 8'h80);
      cmd({4'h8, i[3:0]});
      check(halted, 16'h0000);
    end
    @(posedge clk);
    clkEn <= 1'b0;
    cmd(8'h4f);
    check(halted, 16'h0000);
    clkEn <= 1'b1;
    $display("test stall done");
    pulse(4'h4, 4'h2);
    rd(8'hd2, 8'h30);
    pulse(4'h1, 4'h2);
    check(nakOut, 1'b1);
    cmd(8'h72);
    rd(8'hd2, 8'h10);
    pulse(4'h1, 4'h2);
    check(nakOut, 1'b0);
    cmd(8'h42);
    cmd(8'h82);
    rd(8'hd2, 8'h00);
    cmd(8'h71);
    cmd(8'h60);
    rd(8'hd1, 8'h00);
    rd(8'hd0, 8'h00);
    $display("test out buffer done");
    cmd(8'h63);
    rd(8'hd3, 8'h22);
    cmd(8'h63);
    rd(8'hd3, 8'h60);
    cmd(8'h73);
    rd(8'hd3, 8'h42);
    cmd(8'h64);
    pulse(4'h2, 4'h4);
    rd(8'hd4, 8'h10);
    $display("test in buffer done");
    pulse(4'h8, 4'h0);
    rd(8'hd0, 8'h24);
    cmd(8'h61);
    rd(8'hd1, 8'h00);
    pulse(4'h8, 4'h0);
    rd(8'hd0, 8'h2c);
    rd(8'hd0, 8'h2c);
    rd(8'h50, 8'h2c);
    rd(8'hd0, 8'h24);
    cmd(8'hf4);
    cmd(8'h61);
    rd(8'hd1, 8'h20);
    cmd(8'h41);
    pulse(4'h8, 4'h0);
    check(halted, 16'h0000);
    rd(8'hd1, 8'h00);
    cmd(8'h41);
    check(halted, 16'h0002);
    $display("test setup done");
    @(posedge clk);
    irq <= 16'h0020;
    @(posedge clk);
    irq <= 16'h0000;
    rd(8'hd5, 8'h00);
    check(irqFlags, 16'h0020);
    rd(8'h55, 8'h00);
    check(irqFlags, 16'h0000);
    $display("test interrupt done");
    summarize();
  end
endmodule
